// ===== dv/adcc_afe_model.sv
// partner: analog front end comparator and real-time counter trigger
module adcc_afe_model (
  input wire logic clock_i,
  input wire logic [2:0] mux_src_i,
  input wire logic [11:0] dac_code_i,
  input wire logic [11:0] level_i,
  input wire logic rtc_run_i,
  output logic cmp_above_o,
  output logic rtc_match_o
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] RTC_MOD = 8'h05;
  logic [11:0] ain;
  logic flip = 1'b0;
  logic [1:0] pre = 2'h0;
  logic [7:0] cnt = 8'h00;
  assign ain = (mux_src_i == adcctl_pkg::SRC_VREFH) ? 12'hFFF :
    (mux_src_i == adcctl_pkg::SRC_VREFL) ? 12'h000 : level_i;
  // reserved inputs have no defined level: comparator wanders
  assign cmp_above_o = (mux_src_i == adcctl_pkg::SRC_RESERVED) ? flip :
    (ain >= dac_code_i);
  // counter steps every 4 clocks so a match stands 4 clocks
  always @(posedge clock_i) begin
    flip <= !flip;
    pre <= rtc_run_i ? pre + 2'h1 : 2'h0;
    if (!rtc_run_i) begin
      cnt <= 8'h00;
    end else if (pre == 2'h3) begin
      cnt <= (cnt == RTC_MOD) ? 8'h00 : cnt + 8'h01;
    end
  end
  assign rtc_match_o = rtc_run_i && cnt == RTC_MOD;
endmodule

// ===== dv/adcc_checker.sv
// checker: port-level properties of the adc control block
module adcc_checker (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [2:0] mux_src_o,
  input wire logic [4:0] channel_select_o,
  input wire logic [11:0] dac_code_o,
  input wire logic sample_o,
  input wire logic conv_active_o,
  input wire logic conv_irq_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  okay_resp_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  rd_idle_a: assert property (!$past(hsel && hready && htrans[1]) |->
    hrdata == 32'h0) else $error("read data outside data phase");
  pin_mux_a: assert property (channel_select_o <= 5'h05 |->
    mux_src_o == adcctl_pkg::SRC_PIN) else $error("pin code misrouted");
  refh_mux_a: assert property (channel_select_o == 5'h1D |->
    mux_src_o == adcctl_pkg::SRC_VREFH) else $error("high ref misrouted");
  rsv_mux_a: assert property (channel_select_o inside
    {[5'h16:5'h19], 5'h1C} |-> mux_src_o == adcctl_pkg::SRC_RESERVED)
    else $error("reserved code misrouted");
  temp_mux_a: assert property (channel_select_o == 5'h1A |->
    mux_src_o == adcctl_pkg::SRC_TEMP) else $error("temp code misrouted");
  off_stop_a: assert property (channel_select_o == 5'h1F &&
    $past(channel_select_o) == 5'h1F |-> !conv_active_o && !sample_o &&
    mux_src_o == adcctl_pkg::SRC_NONE) else $error("off code still active");
  dac_msb_a: assert property ($fell(sample_o) && conv_active_o |->
    dac_code_o == 12'h800) else $error("first trial is not the msb");
  irq_src_a: assert property ($rose(conv_irq_o) |->
    $past(conv_active_o)) else $error("irq without a conversion");

  cover property ($fell(conv_active_o));
  cover property ($rose(conv_irq_o));
  cover property (mux_src_o == adcctl_pkg::SRC_TEMP && conv_active_o);
endmodule

bind adcc_top adcc_checker chk (.clock_i(clock_i), .srst_i(srst_i),
  .hsel(hsel), .htrans(htrans), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .mux_src_o(mux_src_o),
  .channel_select_o(channel_select_o), .dac_code_o(dac_code_o),
  .sample_o(sample_o), .conv_active_o(conv_active_o),
  .conv_irq_o(conv_irq_o));

// ===== dv/tb_top.sv
// testbench: register bus scenarios for the adc control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 0, srst_i = 1, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic lclk = 0, aclk = 0, wait_m = 0, stop3_m = 0, rtc_run = 0;
  logic [11:0] level = 0;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, cmp_above, rtc_match, sample, act, irq;
  wire logic [2:0] src;
  wire logic [4:0] ch;
  wire logic [15:0] pins;
  wire logic [11:0] dac;
  int errors = 0, compares = 0;

  initial forever #50 clock_i = !clock_i;
  initial forever #350 lclk = !lclk;
  initial forever #450 aclk = !aclk;

  adcc_top #(.DIV_W(2)) uut (.clock_i(clock_i), .srst_i(srst_i),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .local_async_conv_clock_i(lclk),
    .alternate_clock_input_i(aclk), .rtc_match_i(rtc_match),
    .cmp_above_i(cmp_above), .wait_mode_i(wait_m), .stop3_mode_i(stop3_m),
    .mux_src_o(src), .channel_select_o(ch), .pin_enable_o(pins),
    .dac_code_o(dac), .sample_o(sample), .conv_active_o(act),
    .conv_irq_o(irq));
  adcc_afe_model afe (.clock_i(clock_i), .mux_src_i(src), .dac_code_i(dac),
    .level_i(level), .rtc_run_i(rtc_run), .cmp_above_o(cmp_above),
    .rtc_match_o(rtc_match));

  // ------------------------------------------------------------
  // checking and bus tasks
  // ------------------------------------------------------------
  task automatic tally_and_finish;
    if (errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clock_i);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    for (n = 0; n < 2; n++) begin
      int k;
      k = 0;
      do begin
        @(posedge clock_i);
        k++;
      end while (hreadyout !== 1'b1 && k < 50);
      if (k >= 50) begin
        errors++;
        tally_and_finish();
      end
      hsel <= 0;
      htrans <= 2'h0;
      hwdata <= w ? d : 32'h0;
    end
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
    #1;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic wait_act(input logic lvl, output int c);
    c = 0;
    while (act !== lvl && c < 5000) begin
      @(posedge clock_i);
      #1;
      c++;
    end
    if (c >= 5000) begin
      errors++;
      tally_and_finish();
    end
  endtask
  function automatic logic [2:0] exp_src(input int c);
    if (c <= 5) return 3'h0;
    if (c == 8 || c == 9) return 3'h1;
    if (c <= 21 || c == 30) return 3'h2;
    if (c == 26) return 3'h4;
    if (c == 27) return 3'h5;
    if (c == 29) return 3'h3;
    return (c == 31) ? 3'h7 : 3'h6;
  endfunction

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    rdchk(8'h00, 32'h1F);
    rdchk(8'h04, 32'h0);
    rdchk(8'h10, 32'h0);
    rdchk(8'h20, 32'h0);
    chk(32'(src), 32'h7);
  endtask
  task automatic t_mux;
    for (int c = 0; c < 32; c++) begin
      // bandgap buffer is taken as enabled before code 27 is chosen
      wr(8'h00, c);
      chk(32'(src), 32'(exp_src(c)));
    end
  endtask
  task automatic t_conv;
    int c;
    logic [1:0] fmt [3] = '{2'h1, 2'h2, 2'h0};
    int sh [3] = '{0, 2, 4};
    level <= 12'hA5C;
    for (int i = 0; i < 3; i++) begin
      wr(8'h10, {28'h0, fmt[i], 2'h0});
      wr(8'h00, 32'h1A);
      wait_act(1'b0, c);
      rdchk(8'h00, 32'h9A);
      rdchk(8'h08, 32'(12'hA5C >> sh[i]));
      rdchk(8'h00, 32'h1A);
    end
  endtask
  task automatic t_cont_abort;
    int c;
    wr(8'h00, 32'h60);
    repeat (40) @(posedge clock_i);
    chk(32'(irq & act), 32'h1);
    wr(8'h00, 32'h1F);
    repeat (40) @(posedge clock_i);
    chk(32'({irq, act}), 32'h0);
    wr(8'h00, 32'h00);
    repeat (10) @(posedge clock_i);
    wr(8'h00, 32'h00);
    wait_act(1'b0, c);
    chk(32'(c >= 14 && irq === 1'b0), 32'h1);
    rdchk(8'h00, 32'h80);
  endtask
  task automatic t_cmp;
    int c;
    logic [13:0] tbl [4] = '{{2'h3, 12'h500}, {2'h2, 12'h300},
      {2'h1, 12'h300}, {2'h0, 12'h500}};
    wr(8'h0C, 32'h400);
    for (int i = 0; i < 4; i++) begin
      level <= tbl[i][11:0];
      wr(8'h04, {26'h0, 1'b1, tbl[i][13], 4'h0});
      wr(8'h00, 32'h00);
      wait_act(1'b0, c);
      rdchk(8'h00, {24'h0, tbl[i][12], 7'h0});
    end
    wr(8'h04, 32'h0);
  endtask
  task automatic t_hw;
    int c;
    wr(8'h04, 32'h40);
    wait_m <= 1;
    // low-voltage enables taken as set; bus clock is the source in stop3
    stop3_m <= 1;
    wr(8'h00, 32'h00);
    repeat (30) @(posedge clock_i);
    chk(32'(act), 32'h0);
    rtc_run <= 1;
    wait_act(1'b1, c);
    rtc_run <= 0;
    wait_act(1'b0, c);
    rdchk(8'h00, 32'h80);
    repeat (60) @(posedge clock_i);
    chk(32'(act), 32'h0);
    stop3_m <= 0;
    wr(8'h04, 32'h0);
  endtask
  task automatic t_clk;
    int c;
    int lo [4] = '{28, 56, 260, 200};
    int hi [4] = '{36, 70, 300, 240};
    for (int s = 0; s < 4; s++) begin
      wr(8'h10, 32'h24 | s);
      wr(8'h00, 32'h00);
      wait_act(1'b0, c);
      chk(32'(c >= lo[s] && c <= hi[s]), 32'h1);
    end
  endtask
  task automatic t_pins;
    wr(8'h14, 32'hFFFFFFA5);
    wr(8'h18, 32'h3C);
    chk(32'(pins), 32'h3CA5);
    rdchk(8'h14, 32'hA5);
  endtask

  initial begin
    repeat (20) @(posedge clock_i);
    srst_i <= 0;
    t_reset();
    t_mux();
    t_pins();
    t_conv();
    t_cont_abort();
    t_cmp();
    t_hw();
    t_clk();
    tally_and_finish();
  end
endmodule

// ===== hw/adcc_clkgen.sv
// conversion clock tick generator: source select and programmable divider
module adcc_clkgen #(
  parameter int DIV_W = 2
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [1:0] src_sel_i,
  input wire logic [DIV_W-1:0] div_sel_i,
  input wire logic local_async_conv_clock_i,
  input wire logic alternate_clock_input_i,
  output logic tick_o
);

  // ------------------------------------------------------------------
  // external clock edge detection (three stage synchronisers)
  // ------------------------------------------------------------------
  logic [2:0] loc_sync_ff;
  logic [2:0] alt_sync_ff;
  logic loc_lvl_ff;
  logic alt_lvl_ff;
  logic bus2_ff;
  logic [6:0] div_cnt_ff;
  logic src_tick;
  logic loc_rise;
  logic alt_rise;
  logic [6:0] div_last;

  // a change counts once stages two and three agree
  assign loc_rise = (loc_sync_ff[2] == loc_sync_ff[1]) &&
                    loc_sync_ff[2] && !loc_lvl_ff;
  assign alt_rise = (alt_sync_ff[2] == alt_sync_ff[1]) &&
                    alt_sync_ff[2] && !alt_lvl_ff;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      loc_sync_ff <= 3'h0;
      alt_sync_ff <= 3'h0;
      loc_lvl_ff <= 1'b0;
      alt_lvl_ff <= 1'b0;
      bus2_ff <= 1'b0;
    end else begin
      loc_sync_ff <= {loc_sync_ff[1:0], local_async_conv_clock_i};
      alt_sync_ff <= {alt_sync_ff[1:0], alternate_clock_input_i};
      if (loc_sync_ff[2] == loc_sync_ff[1]) loc_lvl_ff <= loc_sync_ff[2];
      if (alt_sync_ff[2] == alt_sync_ff[1]) alt_lvl_ff <= alt_sync_ff[2];
      bus2_ff <= !bus2_ff;
    end
  end

  // ------------------------------------------------------------------
  // source select and divider
  // ------------------------------------------------------------------
  assign src_tick = (src_sel_i == adcctl_pkg::CLK_BUS) ? 1'b1 :
                    (src_sel_i == adcctl_pkg::CLK_BUS2) ? bus2_ff :
                    (src_sel_i == adcctl_pkg::CLK_ALT) ? alt_rise :
                    loc_rise;
  // divide by 2 to the power of the select
  assign div_last = 7'((1 << div_sel_i) - 1);

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      div_cnt_ff <= 7'h00;
      tick_o <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (src_tick) begin
        if (div_cnt_ff >= div_last) begin
          div_cnt_ff <= 7'h00;
          tick_o <= 1'b1;
        end else begin
          div_cnt_ff <= div_cnt_ff + 7'h01;
        end
      end
    end
  end

endmodule

// ===== hw/adcc_top.sv
// adc digital control: registers, channel decode, trigger and sequencer

// Overview of operation
// - codes 0-5 select pins, 8-9 comparator pins, other low codes low reference
// - reserved codes still convert; result undefined
// - code 11010 selects the temperature sensor
// - conversion clock source chosen from bus, bus/2, local, alternate
// - selected source divided by the clock divide select field
// - alternate clock keeps running during wait mode
// - hardware trigger select starts conversion on counter modulo match
// - match triggers whether or not counter interrupt is enabled
// - hardware trigger works in run, wait and stop3
// - two pin-enable registers cover codes 0 to 15 only
// - results right-justified unsigned in 12, 10 or 8 bits
// - single conversion returns idle; continuous repeats back to back
// - compare result with value, less-than or greater-or-equal
// - completion flag with its interrupt request
// - asynchronous hardware trigger selectable instead of software start
// - linear successive approximation, one bit per step, 12 bits
// - all-ones channel switches off converter, ends continuous mode
// - control write aborts conversion and restarts unless channel all ones or hardware trigger selected
// - flag per compare setting; cleared by control write or low read
module adcc_top #(
  parameter int DIV_W = 2
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic local_async_conv_clock_i,
  input wire logic alternate_clock_input_i,
  input wire logic rtc_match_i,
  input wire logic cmp_above_i,
  input wire logic wait_mode_i,
  input wire logic stop3_mode_i,
  output logic [2:0] mux_src_o,
  output logic [4:0] channel_select_o,
  output logic [15:0] pin_enable_o,
  output logic [11:0] dac_code_o,
  output logic sample_o,
  output logic conv_active_o,
  output logic conv_irq_o
);

  typedef enum logic [1:0] {S_IDLE, S_SAMPLE, S_APPROX} adcc_state_t;

  // ------------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------------
  logic wr_pend_ff;
  logic rd_pend_ff;
  logic [7:0] ofs_ff;
  logic [7:0] cs1_ff;
  logic [7:0] cs2_ff;
  logic [7:0] cfg_ff;
  logic [7:0] pin1_ff;
  logic [7:0] pin2_ff;
  logic [11:0] cmp_ff;
  logic [11:0] result_ff;
  logic flag_ff;
  logic addr_ok;
  logic wr_cs1;
  logic wr_ch_off;
  logic rd_low;
  logic [31:0] rd_mux;

  assign addr_ok = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wr_cs1 = wr_pend_ff && ofs_ff == adcctl_pkg::OFS_CS1;
  // the channel being written decides, not the one it replaces
  assign wr_ch_off = hwdata[4:0] == adcctl_pkg::CH_OFF;
  assign rd_low = rd_pend_ff && ofs_ff == adcctl_pkg::OFS_RESULT;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      ofs_ff <= 8'h00;
    end else begin
      wr_pend_ff <= addr_ok && hwrite;
      rd_pend_ff <= addr_ok && !hwrite;
      if (addr_ok) ofs_ff <= haddr[7:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cs1_ff <= adcctl_pkg::CS1_RST;
      cs2_ff <= adcctl_pkg::CS2_RST;
      cfg_ff <= adcctl_pkg::CFG_RST;
      pin1_ff <= adcctl_pkg::PIN_RST;
      pin2_ff <= adcctl_pkg::PIN_RST;
      cmp_ff <= adcctl_pkg::CMP_RST;
    end else if (wr_pend_ff) begin
      case (ofs_ff)
        adcctl_pkg::OFS_CS1: cs1_ff <= {1'b0, hwdata[6:0]};
        adcctl_pkg::OFS_CS2: cs2_ff <= {1'b0, hwdata[6:4], 4'h0};
        adcctl_pkg::OFS_CFG: cfg_ff <= hwdata[7:0];
        adcctl_pkg::OFS_PIN1: pin1_ff <= hwdata[7:0];
        adcctl_pkg::OFS_PIN2: pin2_ff <= hwdata[7:0];
        adcctl_pkg::OFS_CMPVAL: cmp_ff <= hwdata[11:0];
        default: ;
      endcase
    end
  end

  adcc_state_t state_ff;
  logic hwt_ff;

  assign rd_mux =
    (ofs_ff == adcctl_pkg::OFS_CS1) ? {24'h0, flag_ff, cs1_ff[6:0]} :
    (ofs_ff == adcctl_pkg::OFS_CS2) ?
      {24'h0, conv_active_o, cs2_ff[6:0]} :
    (ofs_ff == adcctl_pkg::OFS_RESULT) ? {20'h0, result_ff} :
    (ofs_ff == adcctl_pkg::OFS_CMPVAL) ? {20'h0, cmp_ff} :
    (ofs_ff == adcctl_pkg::OFS_CFG) ? {24'h0, cfg_ff} :
    (ofs_ff == adcctl_pkg::OFS_PIN1) ? {24'h0, pin1_ff} :
    (ofs_ff == adcctl_pkg::OFS_PIN2) ? {24'h0, pin2_ff} :
    (ofs_ff == adcctl_pkg::OFS_STAT) ?
      {29'h0, hwt_ff, state_ff} : 32'h0;
  assign hrdata = rd_pend_ff ? rd_mux : 32'h0;

  // ------------------------------------------------------------------
  // channel decode
  // ------------------------------------------------------------------
  logic [4:0] ch;
  logic ch_off;
  adcctl_pkg::adcc_src_t src;

  assign ch = cs1_ff[4:0];
  assign ch_off = ch == adcctl_pkg::CH_OFF;
  assign src =
    (ch <= adcctl_pkg::CH_PIN_LAST) ? adcctl_pkg::SRC_PIN :
    (ch == adcctl_pkg::CH_CMP_P || ch == adcctl_pkg::CH_CMP_M) ?
      adcctl_pkg::SRC_CMP_PIN :
    (ch <= adcctl_pkg::CH_LOWREF_LAST) ? adcctl_pkg::SRC_VREFL :
    (ch >= adcctl_pkg::CH_RSV_FIRST && ch <= adcctl_pkg::CH_RSV_LAST) ?
      adcctl_pkg::SRC_RESERVED :
    (ch == adcctl_pkg::CH_TEMP) ? adcctl_pkg::SRC_TEMP :
    (ch == adcctl_pkg::CH_BANDGAP) ? adcctl_pkg::SRC_BANDGAP :
    (ch == adcctl_pkg::CH_RSV_HI) ? adcctl_pkg::SRC_RESERVED :
    (ch == adcctl_pkg::CH_VREFH) ? adcctl_pkg::SRC_VREFH :
    (ch == adcctl_pkg::CH_VREFL) ? adcctl_pkg::SRC_VREFL :
    adcctl_pkg::SRC_NONE;
  assign mux_src_o = src;
  assign channel_select_o = ch;
  assign pin_enable_o = {pin2_ff, pin1_ff};

  // ------------------------------------------------------------------
  // conversion clock
  // ------------------------------------------------------------------
  logic tick;

  // the block's logic is held clocked in wait and stop3, so the chosen
  // source keeps ticking there when it is running
  adcc_clkgen #(
    .DIV_W(DIV_W)
  ) u_clkgen (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .src_sel_i(cfg_ff[1:0]),
    .div_sel_i(cfg_ff[adcctl_pkg::CFG_DIV_POS +: DIV_W]),
    .local_async_conv_clock_i(local_async_conv_clock_i),
    .alternate_clock_input_i(alternate_clock_input_i),
    .tick_o(tick)
  );

  // ------------------------------------------------------------------
  // hardware trigger crossing
  // ------------------------------------------------------------------
  logic [2:0] trg_sync_ff;
  logic trg_lvl_ff;
  logic trg_pend_ff;
  logic trg_rise;
  logic hw_sel;

  assign hw_sel = cs2_ff[adcctl_pkg::CS2_HWT_POS];
  // mode pins are not consulted: the trigger runs in run, wait and stop3
  assign trg_rise = (trg_sync_ff[2] == trg_sync_ff[1]) &&
                    trg_sync_ff[2] && !trg_lvl_ff;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      trg_sync_ff <= 3'h0;
      trg_lvl_ff <= 1'b0;
    end else begin
      trg_sync_ff <= {trg_sync_ff[1:0], rtc_match_i};
      if (trg_sync_ff[2] == trg_sync_ff[1]) trg_lvl_ff <= trg_sync_ff[2];
    end
  end

  // ------------------------------------------------------------------
  // successive approximation sequencer
  // ------------------------------------------------------------------
  logic [11:0] sar_ff;
  logic [3:0] bit_ff;
  logic [2:0] samp_ff;
  logic cont_ff;
  logic done;
  logic [11:0] trial;
  logic [11:0] final_code;
  logic cmp_true;
  logic start_sw;
  logic start_hw;
  logic [1:0] mode;

  assign mode = cfg_ff[adcctl_pkg::CFG_MODE_POS +: 2];
  assign start_sw = wr_cs1 && !wr_ch_off && !hw_sel;
  // a control write wins over a pending trigger, which then stays pending
  assign start_hw = hw_sel && trg_pend_ff && !ch_off && !wr_cs1 &&
                    state_ff == S_IDLE && tick;
  assign trial = sar_ff | (12'h001 << bit_ff);
  assign final_code = cmp_above_i ? trial : sar_ff;
  assign done = state_ff == S_APPROX && tick && bit_ff == 4'h0;
  assign cmp_true = cs2_ff[adcctl_pkg::CS2_ACFGT_POS] ?
                    (fmt(final_code, mode) >= fmt(cmp_ff, mode)) :
                    (fmt(final_code, mode) < fmt(cmp_ff, mode));

  // right-justified formats
  function automatic logic [11:0] fmt(input logic [11:0] v,
                                      input logic [1:0] m);
    case (m)
      adcctl_pkg::MODE_8: fmt = {4'h0, v[11:4]};
      adcctl_pkg::MODE_10: fmt = {2'h0, v[11:2]};
      default: fmt = v;
    endcase
  endfunction

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      trg_pend_ff <= 1'b0;
      hwt_ff <= 1'b0;
    end else begin
      hwt_ff <= hw_sel;
      if (trg_rise && hw_sel) trg_pend_ff <= 1'b1;
      else if (start_hw || !hw_sel) trg_pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_ff <= S_IDLE;
      sar_ff <= 12'h000;
      bit_ff <= 4'h0;
      samp_ff <= 3'h0;
      cont_ff <= 1'b0;
    end else if (wr_cs1 && (wr_ch_off || hw_sel)) begin
      state_ff <= S_IDLE;
    end else if (start_sw || start_hw) begin
      state_ff <= S_SAMPLE;
      samp_ff <= 3'h0;
      cont_ff <= start_sw ? hwdata[adcctl_pkg::CS1_CONT_POS] :
                 cs1_ff[adcctl_pkg::CS1_CONT_POS];
    end else begin
      case (state_ff)
        S_IDLE: ;
        S_SAMPLE: begin
          if (tick) begin
            if (samp_ff == 3'(adcctl_pkg::SAMPLE_TICKS - 1)) begin
              state_ff <= S_APPROX;
              sar_ff <= 12'h000;
              bit_ff <= 4'(adcctl_pkg::RES_BITS - 1);
            end else begin
              samp_ff <= samp_ff + 3'h1;
            end
          end
        end
        S_APPROX: begin
          if (tick) begin
            if (cmp_above_i) sar_ff <= trial;
            if (bit_ff == 4'h0) begin
              samp_ff <= 3'h0;
              state_ff <= (cont_ff && !ch_off) ? S_SAMPLE : S_IDLE;
            end else begin
              bit_ff <= bit_ff - 4'h1;
            end
          end
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  logic cmp_en;
  assign cmp_en = cs2_ff[adcctl_pkg::CS2_CMPEN_POS];

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      result_ff <= 12'h000;
      flag_ff <= 1'b0;
    end else begin
      if (done && (!cmp_en || cmp_true)) begin
        result_ff <= fmt(final_code, mode);
        flag_ff <= 1'b1;
      end else if (wr_cs1 || rd_low) begin
        flag_ff <= 1'b0;
      end
    end
  end

  assign dac_code_o = trial;
  assign sample_o = state_ff == S_SAMPLE;
  assign conv_active_o = state_ff != S_IDLE;
  assign conv_irq_o = flag_ff && cs1_ff[adcctl_pkg::CS1_AIEN_POS];

endmodule

// ===== hw/adcctl_pkg.sv
// package: register map, field positions, reset values and codes of the adc control block
package adcctl_pkg;

  // ------------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_CS1 = 8'h00;
  localparam logic [7:0] OFS_CS2 = 8'h04;
  localparam logic [7:0] OFS_RESULT = 8'h08;
  localparam logic [7:0] OFS_CMPVAL = 8'h0C;
  localparam logic [7:0] OFS_CFG = 8'h10;
  localparam logic [7:0] OFS_PIN1 = 8'h14;
  localparam logic [7:0] OFS_PIN2 = 8'h18;
  localparam logic [7:0] OFS_STAT = 8'h1C;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int CS1_FLAG_POS = 7;
  localparam int CS1_AIEN_POS = 6;
  localparam int CS1_CONT_POS = 5;
  localparam int CS2_ACT_POS = 7;
  localparam int CS2_HWT_POS = 6;
  localparam int CS2_CMPEN_POS = 5;
  localparam int CS2_ACFGT_POS = 4;
  localparam int CFG_MODE_POS = 2;
  localparam int CFG_DIV_POS = 5;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] CS1_RST = 8'h1F;
  localparam logic [7:0] CS2_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] PIN_RST = 8'h00;
  localparam logic [11:0] CMP_RST = 12'h000;

  // ------------------------------------------------------------------
  // channel codes
  // ------------------------------------------------------------------
  localparam logic [4:0] CH_PIN_LAST = 5'h05;
  localparam logic [4:0] CH_CMP_P = 5'h08;
  localparam logic [4:0] CH_CMP_M = 5'h09;
  localparam logic [4:0] CH_LOWREF_LAST = 5'h15;
  localparam logic [4:0] CH_RSV_FIRST = 5'h16;
  localparam logic [4:0] CH_RSV_LAST = 5'h19;
  localparam logic [4:0] CH_TEMP = 5'h1A;
  localparam logic [4:0] CH_BANDGAP = 5'h1B;
  localparam logic [4:0] CH_RSV_HI = 5'h1C;
  localparam logic [4:0] CH_VREFH = 5'h1D;
  localparam logic [4:0] CH_VREFL = 5'h1E;
  localparam logic [4:0] CH_OFF = 5'h1F;

  // analog mux source codes driven to the analog front end
  typedef enum logic [2:0] {
    SRC_PIN, SRC_CMP_PIN, SRC_VREFL, SRC_VREFH,
    SRC_TEMP, SRC_BANDGAP, SRC_RESERVED, SRC_NONE
  } adcc_src_t;

  // result formats
  localparam logic [1:0] MODE_8 = 2'h0;
  localparam logic [1:0] MODE_12 = 2'h1;
  localparam logic [1:0] MODE_10 = 2'h2;

  // clock sources
  localparam logic [1:0] CLK_BUS = 2'h0;
  localparam logic [1:0] CLK_BUS2 = 2'h1;
  localparam logic [1:0] CLK_ALT = 2'h2;
  localparam logic [1:0] CLK_LOCAL = 2'h3;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int RES_BITS = 12;
  localparam int SAMPLE_TICKS = 4;
  localparam logic [2:0] SYNC_DEPTH = 3'h3;

endpackage
